// [hdl/pafm_mux.sv]
`timescale 1ns/1ps
`default_nettype none
module pafm_mux
  import pafm_pkg::*;
(
  input  wire logic       clk_in,          // 50 MHz clock
  input  wire logic       resetn_in,       // async reset, active low
  input  wire logic       ce_in,           // clock enable
  input  wire pafm_cfg_t  cfg_in,          // port configuration bits
  input  wire logic       debug_pin_enable_bit_in, // debug takes shared pin
  input  wire logic       buffer_off_in,   // idle, stop or bus hold
  input  wire logic [7:0] rising_edge_select_bit_in,  // rising sensitivity
  input  wire logic [7:0] falling_edge_select_bit_in, // falling sensitivity
  input  wire pafm_alt_t  alt_in,          // peripheral outputs and enables
  input  wire logic [7:0] pin_in,          // pin levels
  output logic [7:0]      pin_out,         // pin drive value
  output logic [7:0]      pin_oe_out,      // pin drive enable
  output logic [7:0]      port_read_out,   // port read data
  output logic [7:0]      alt_a_in_out,    // first-function inputs
  output logic [7:0]      alt_b_in_out,    // second-function inputs
  output logic [7:0]      alt_c_in_out,    // third-function inputs
  output logic [7:0]      alt_d_in_out,    // fourth-function inputs
  output logic [7:0]      edge_event_out,  // filtered edge pulses
  output logic            debug_reset_input_out // debug reset input
);
  // pin synchroniser
  logic [7:0] sync1;
  logic [7:0] sync2;
  logic [7:0] next_sync1;
  logic [7:0] next_sync2;

  // noise filter and edge detector
  logic [7:0] filt;
  logic [7:0] prev_filt;
  logic [7:0] edg;
  logic [1:0] cnt            [PIN_COUNT];
  logic [7:0] next_filt;
  logic [7:0] next_prev_filt;
  logic [7:0] next_edg;
  logic [1:0] next_cnt       [PIN_COUNT];

  // pin multiplexer
  logic [7:0] pin;
  logic [7:0] oe;
  logic [7:0] rd;
  logic [7:0] ain_a;
  logic [7:0] ain_b;
  logic [7:0] ain_c;
  logic [7:0] ain_d;
  logic       dbg;
  logic [7:0] next_pin;
  logic [7:0] next_oe;
  logic [7:0] next_rd;
  logic [7:0] next_a;
  logic [7:0] next_b;
  logic [7:0] next_c;
  logic [7:0] next_d;
  logic       next_dbg;

  function automatic logic [1:0] fsel(input pafm_cfg_t c, input int i);
    fsel = {c.sel_ext[i], c.sel[i]};
  endfunction

  always_comb begin
    next_sync1 = pin_in;
    next_sync2 = sync1;
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sync1 <= 8'h00;
      sync2 <= 8'h00;
    end else if (ce_in) begin
      sync1 <= next_sync1;
      sync2 <= next_sync2;
    end
  end

  // a level must differ for NOISE_LEN cycles before it is accepted
  always_comb begin
    next_filt = filt;
    next_prev_filt = filt;
    for (int i = 0; i < PIN_COUNT; i++) begin
      next_cnt[i] = cnt[i];
      if (sync2[i] == filt[i]) begin
        next_cnt[i] = 2'h0;
      end else if (cnt[i] == 2'(NOISE_LEN - 1)) begin
        next_filt[i] = sync2[i];
        next_cnt[i] = 2'h0;
      end else begin
        next_cnt[i] = cnt[i] + 2'h1;
      end
    end
    next_edg = (filt & ~prev_filt & rising_edge_select_bit_in) |
               (~filt & prev_filt & falling_edge_select_bit_in);
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      filt <= 8'h00;
      prev_filt <= 8'h00;
      edg <= 8'h00;
      for (int i = 0; i < PIN_COUNT; i++) begin
        cnt[i] <= 2'h0;
      end
    end else if (ce_in) begin
      filt <= next_filt;
      prev_filt <= next_prev_filt;
      edg <= next_edg;
      cnt <= next_cnt;
    end
  end

  always_comb begin
    next_dbg = debug_pin_enable_bit_in & sync2[PIN_DEBUG];
    for (int i = 0; i < PIN_COUNT; i++) begin
      next_a[i] = cfg_in.mode[i] & sync2[i];
      next_b[i] = cfg_in.mode[i] & sync2[i];
      next_c[i] = cfg_in.mode[i] & (fsel(cfg_in, i) == 2'h2) & sync2[i];
      next_d[i] = 1'b0;
      next_rd[i] = cfg_in.dir[i] ? sync2[i] : cfg_in.latch[i];
      if (!cfg_in.mode[i]) begin
        next_pin[i] = cfg_in.latch[i];
        next_oe[i] = ~cfg_in.dir[i];
      end else if (i == PIN_QUAD) begin
        unique case (fsel(cfg_in, i))
          2'h0: begin next_pin[i] = 1'b0; next_oe[i] = 1'b0; end
          2'h1: begin next_pin[i] = alt_in.out_b[i]; next_oe[i] = alt_in.oe_b[i]; end
          2'h2: begin next_pin[i] = 1'b0; next_oe[i] = 1'b0; end
          2'h3: begin next_pin[i] = alt_in.out_d[i]; next_oe[i] = alt_in.oe_d[i]; end
        endcase
      end else if (cfg_in.sel[i]) begin
        next_pin[i] = alt_in.out_b[i];
        next_oe[i] = alt_in.oe_b[i];
      end else begin
        next_pin[i] = alt_in.out_a[i];
        next_oe[i] = alt_in.oe_a[i];
      end
      if (i == PIN_DEBUG && debug_pin_enable_bit_in) begin
        next_oe[i] = 1'b0;
        next_a[i] = 1'b0;
        next_b[i] = 1'b0;
      end
      if (buffer_off_in) begin
        next_oe[i] = 1'b0;
      end
    end
  end

  // outputs only change on enabled edges or at async reset
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pin <= 8'h00;
      oe <= 8'h00;
      rd <= 8'h00;
      ain_a <= 8'h00;
      ain_b <= 8'h00;
      ain_c <= 8'h00;
      ain_d <= 8'h00;
      dbg <= 1'b0;
    end else if (ce_in) begin
      pin <= next_pin;
      oe <= next_oe;
      rd <= next_rd;
      ain_a <= next_a;
      ain_b <= next_b;
      ain_c <= next_c;
      ain_d <= next_d;
      dbg <= next_dbg;
    end
  end

  assign pin_out = pin;
  assign pin_oe_out = oe;
  assign port_read_out = rd;
  assign alt_a_in_out = ain_a;
  assign alt_b_in_out = ain_b;
  assign alt_c_in_out = ain_c;
  assign alt_d_in_out = ain_d;
  assign edge_event_out = edg;
  assign debug_reset_input_out = dbg;
endmodule
`default_nettype wire

// [pkg/pafm_pkg.sv]
package pafm_pkg;
  localparam int PIN_COUNT = 8;
  localparam int NOISE_LEN = 3;
  localparam logic [7:0] RST_LATCH = 8'h00;
  localparam logic [7:0] RST_DIR = 8'hFF;
  localparam logic [7:0] RST_MODE = 8'h00;
  localparam logic [7:0] RST_SEL = 8'h00;
  localparam logic [3:0] EXT_CLK_CODE = 4'hB;
  localparam logic [7:0] DAC_DIR_ALL = 8'hFF;
  localparam int PIN_SHARED_RX = 1;
  localparam int PIN_QUAD = 3;
  localparam int PIN_DEBUG = 5;
  typedef struct packed {
    logic [7:0] latch;
    logic [7:0] dir;
    logic [7:0] mode;
    logic [7:0] sel;
    logic [7:0] sel_ext;
  } pafm_cfg_t;
  typedef struct packed {
    logic [7:0] out_a;
    logic [7:0] oe_a;
    logic [7:0] out_b;
    logic [7:0] oe_b;
    logic [7:0] out_c;
    logic [7:0] oe_c;
    logic [7:0] out_d;
    logic [7:0] oe_d;
  } pafm_alt_t;
endpackage

// [testbench/pafm_mux_sva.sv]
`timescale 1ns/1ps
`default_nettype none
module pafm_mux_sva
  import pafm_pkg::*;
(
  input wire logic       clk_in,                  // clock
  input wire logic       resetn_in,               // reset
  input wire logic       ce_in,                   // clock enable
  input wire pafm_cfg_t  cfg_in,                  // port config
  input wire logic       debug_pin_enable_bit_in, // debug owns pin 5
  input wire logic       buffer_off_in,           // buffers off
  input wire pafm_alt_t  alt_in,                  // peripheral side
  input wire logic [7:0] pin_in,                  // pin levels
  input wire logic [7:0] pin_out,                 // drive value
  input wire logic [7:0] pin_oe_out,              // drive enable
  input wire logic [7:0] port_read_out,           // read data
  input wire logic [7:0] alt_a_in_out             // first-function inputs
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  wire logic [7:0] m = cfg_in.mode;
  wire logic       go = ce_in && !buffer_off_in;
  AST_OFF: assert property (ce_in && buffer_off_in |=> pin_oe_out == 8'h00)
    else $error("buffer not off");
  AST_PORT: assert property (go && !m[0] && !cfg_in.dir[0] |=> pin_oe_out[0]
    && pin_out[0] == $past(cfg_in.latch[0])) else $error("port drive");
  AST_RD: assert property (ce_in && !cfg_in.dir[0] |=>
    port_read_out[0] == $past(cfg_in.latch[0])) else $error("port read");
  AST_ALTA: assert property (go && m[0] && !cfg_in.sel[0] |=> pin_out[0] == $past(
    alt_in.out_a[0]) && pin_oe_out[0] == $past(alt_in.oe_a[0])) else $error("alt a");
  AST_ALTB: assert property (go && m[0] && cfg_in.sel[0] |=> pin_out[0] == $past(
    alt_in.out_b[0]) && pin_oe_out[0] == $past(alt_in.oe_b[0])) else $error("alt b");
  AST_QUAD: assert property (go && m[3] && cfg_in.sel_ext[3] && cfg_in.sel[3] |=>
    pin_out[3] == $past(alt_in.out_d[3])) else $error("quad code");
  AST_DBG: assert property (ce_in && debug_pin_enable_bit_in |=> !pin_oe_out[5])
    else $error("debug pin driven");
  AST_RX: assert property ($past(resetn_in, 3) && $past(m[1]) && $past(ce_in)
    && $past(ce_in, 2) && $past(ce_in, 3) |->
    alt_a_in_out[1] == $past(pin_in[1], 3)) else $error("receive path");
endmodule
bind pafm_mux pafm_mux_sva u_sva (.*);
`default_nettype wire

// [testbench/pafm_mux_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) checks_done++; if ((a) !== (e)) begin num_errors++; \
  $display("[ERR] %s exp %h got %h", n, e, a); end
module pafm_mux_tb_top import pafm_pkg::*;;
  logic       clk_in = 0, resetn_in = 0, dbg = 0, boff = 0, ce = 1, dro;
  pafm_cfg_t  cfg = '{8'h00, 8'hFF, 8'h00, 8'h00, 8'h00};
  logic [7:0] rise = 0, fall = 0, pin = 0, po, poe, rd, aa, ab, ac, ad, ev;
  pafm_alt_t  alt;
  int         num_errors = 0, checks_done = 0, cyc = 0;
  // mode, sel, sel_ext, dir, latch, expected drive, expected enable
  logic [55:0] rows [6] = '{56'h0000000F5550F0, 56'hFF0000FFFFA5F7, 56'hFFFF00FFFF3CFF,
    56'hFFFFFFFF0034FF, 56'hFF00FFFF00A5F7, 56'h0F000000F0F5F7};
  pafm_periph u_periph (.alt_out(alt));
  pafm_mux u_dut (.clk_in(clk_in), .resetn_in(resetn_in), .ce_in(ce), .cfg_in(cfg),
    .debug_pin_enable_bit_in(dbg), .buffer_off_in(boff), .rising_edge_select_bit_in(rise),
    .falling_edge_select_bit_in(fall), .alt_in(alt), .pin_in(pin), .pin_out(po),
    .pin_oe_out(poe), .port_read_out(rd), .alt_a_in_out(aa), .alt_b_in_out(ab),
    .alt_c_in_out(ac), .alt_d_in_out(ad), .edge_event_out(ev), .debug_reset_input_out(dro));
  always #10 clk_in = ~clk_in;
  task step(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task results;
    if (num_errors == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      num_errors++;
      results();
    end
  end
  initial begin
    step(10);
    resetn_in = 1;
    step(2);
    `CHK("pin_oe_out", 8'h00, poe)
    foreach (rows[i]) begin
      {cfg.mode, cfg.sel, cfg.sel_ext, cfg.dir, cfg.latch} = rows[i][55:16];
      step(2);
      `CHK("pin_oe_out", rows[i][7:0], poe)
      `CHK("pin_out", rows[i][15:8] & rows[i][7:0], po & rows[i][7:0])
      `CHK("port_read_out", cfg.latch & ~cfg.dir, rd & ~cfg.dir)
    end
    boff = 1;
    step(2);
    `CHK("pin_oe_out", 8'h00, poe)
    boff = 0;
    dbg = 1;
    pin = 8'h20;
    step(5);
    `CHK("pin_oe_out", 1'b0, poe[5])
    `CHK("debug_reset_input_out", 1'b1, dro)
    dbg = 0;
    pin = 8'h00;
    step(5);
    rise = 8'h02;
    pin = 8'h02;
    for (int k = 0; k < 12 && ev[1] !== 1'b1; k++) step(1);
    `CHK("edge_event_out", 1'b1, ev[1])
    `CHK("alt_a_in_out", 1'b1, aa[1])
    step(1);
    `CHK("edge_event_out", 1'b0, ev[1])
    fall = 8'h02;
    pin = 8'h00;
    for (int k = 0; k < 12 && ev[1] !== 1'b1; k++) step(1);
    `CHK("edge_event_out", 1'b1, ev[1])
    cfg.sel_ext = 8'h08;
    pin = 8'h0A;
    step(4);
    `CHK("alt_b_in_out", 8'h0A, ab)
    `CHK("alt_c_in_out", 8'h08, ac)
    `CHK("alt_d_in_out", 8'h00, ad)
    cfg.dir = DAC_DIR_ALL;
    step(2);
    `CHK("pin_oe_out", 8'h07, poe)
    ce = 0;
    boff = 1;
    step(3);
    `CHK("pin_oe_out", 8'h07, poe)
    ce = 1;
    step(2);
    `CHK("pin_oe_out", 8'h00, poe)
    results();
  end
endmodule
`default_nettype wire

// [testbench/pafm_periph.sv]
`timescale 1ns/1ps
`default_nettype none
module pafm_periph
  import pafm_pkg::*;
(
  output var pafm_alt_t alt_out  // peripheral outputs and enables
);
  // pin 3 first function is a capture input, so its enable stays low
  // no trigger or external serial clock is driven here
  assign alt_out = '{8'hA5, 8'hF7, 8'h3C, 8'hFF, 8'h00, 8'h00, 8'hC3, 8'hFF};
endmodule
`default_nettype wire
